/* rtl/rss_map.svh */
// Purpose: named constants of the reset stretch sequencer
// Assumes: slow timing clock nominally 32 kHz, core clock 250 MHz
// Notes:   counts are in slow-clock cycles unless named otherwise
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH

`define RSS_POR_MS          300
`define RSS_SLOW_HZ         32000
`define RSS_POR_CYC         ((`RSS_POR_MS * `RSS_SLOW_HZ) / 1000)
`define RSS_MEM_CYC         7
`define RSS_SYS_CYC         14
`define RSS_QUAL_CYC        4

`endif

/* rtl/rss_pkg.sv */
// Purpose: types of the reset stretch sequencer
// Assumes: nothing beyond the map header
// Notes:   one-hot sequencer states
package rss_pkg;
   typedef enum logic [3:0] {
      RSS_ST_POR  = 4'h1,
      RSS_ST_HOLD = 4'h2,
      RSS_ST_STR  = 4'h4,
      RSS_ST_RUN  = 4'h8
   } rss_state_t;
endpackage : rss_pkg

/* rtl/rss_reset_stretch_sequencer.sv */
// Purpose: power-up pulse, hard-reset qualifier and two reset stretchers
// Assumes: slow timing clock arrives as a pin, sampled on the core clock
// Notes:   all timing counts on slow-clock rising edges
`timescale 1ns/1ps
`default_nettype none
`include "rss_map.svh"

module rss_reset_stretch_sequencer
   import rss_pkg::*;
#(
   parameter int unsigned POR_CYC = `RSS_POR_CYC
) (
   input  wire logic i_core_clk,
   input  wire logic i_nrst,
   input  wire logic i_slow_timing_clock,
   input  wire logic i_hard_rst_n,
   output var  logic o_mem_rst_n,
   output var  logic o_system_rst_internal_n,
   output var  logic o_board_rst_n
);
   localparam int PW = (POR_CYC > 1) ? $clog2(POR_CYC + 1) : 1;

   // pin synchronisers, three stages each
   logic [2:0] clk_sync_q;
   logic [2:0] hrst_sync_q;
   logic       clk_lvl_q;
   logic       hrst_lvl_q;
   logic [2:0] clk_sync_d;
   logic [2:0] hrst_sync_d;
   logic       clk_lvl_d;
   logic       hrst_lvl_d;
   logic       slow_tick;

   always_comb begin
      clk_sync_d  = {clk_sync_q[1:0], i_slow_timing_clock};
      hrst_sync_d = {hrst_sync_q[1:0], ~i_hard_rst_n};
      clk_lvl_d   = (clk_sync_q[1] == clk_sync_q[2]) ? clk_sync_q[2] : clk_lvl_q;
      hrst_lvl_d  = (hrst_sync_q[1] == hrst_sync_q[2]) ? hrst_sync_q[2] : hrst_lvl_q;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         // reset high: a slow clock already high at release is no edge
         clk_sync_q  <= '1;
         hrst_sync_q <= 3'h0;
         clk_lvl_q   <= 1'b1;
         hrst_lvl_q  <= 1'b0;
      end else begin
         clk_sync_q  <= clk_sync_d;
         hrst_sync_q <= hrst_sync_d;
         clk_lvl_q   <= clk_lvl_d;
         hrst_lvl_q  <= hrst_lvl_d;
      end
   end

   // one-cycle enable per slow-clock rising edge
   assign slow_tick = clk_lvl_d & ~clk_lvl_q;

   // hard-reset qualifier
   logic [2:0] qual_q;
   logic [2:0] qual_d;
   logic       hrst_ok;

   always_comb begin
      qual_d = qual_q;
      if (!hrst_lvl_q) begin
         qual_d = 3'h0;
      end else if (slow_tick && (qual_q < 3'(`RSS_QUAL_CYC))) begin
         qual_d = qual_q + 3'h1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         qual_q <= 3'h0;
      end else begin
         qual_q <= qual_d;
      end
   end

   // shorter pulses never reach the count, so they are ignored
   assign hrst_ok = hrst_lvl_q && (qual_q == 3'(`RSS_QUAL_CYC));

   // sequencer and counters
   rss_state_t  st_q;
   rss_state_t  st_d;
   logic [PW-1:0] por_q;
   logic [PW-1:0] por_d;
   logic [3:0]  mem_q;
   logic [3:0]  mem_d;
   logic [3:0]  sys_q;
   logic [3:0]  sys_d;
   logic        mem_rst_n_d;
   logic        sys_rst_n_d;
   logic        mem_rst_n_q;
   logic        sys_rst_n_q;
   logic        board_rst_n_q;

   always_comb begin
      st_d  = st_q;
      por_d = por_q;
      mem_d = mem_q;
      sys_d = sys_q;
      case (st_q)
         RSS_ST_POR: begin
            mem_d = 4'h0;
            sys_d = 4'h0;
            if (slow_tick) begin
               if (por_q >= PW'(POR_CYC - 1)) begin
                  st_d = RSS_ST_STR;
               end else begin
                  por_d = por_q + PW'(1);
               end
            end
         end
         RSS_ST_HOLD: begin
            mem_d = 4'h0;
            sys_d = 4'h0;
            if (!hrst_lvl_q) begin
               st_d = RSS_ST_STR;
            end
         end
         RSS_ST_STR: begin
            if (hrst_ok) begin
               st_d = RSS_ST_HOLD;
            end else if (slow_tick) begin
               if (mem_q < 4'(`RSS_MEM_CYC)) begin
                  mem_d = mem_q + 4'h1;
               end
               if (sys_q < 4'(`RSS_SYS_CYC)) begin
                  sys_d = sys_q + 4'h1;
               end
               if (sys_q == 4'(`RSS_SYS_CYC - 1)) begin
                  st_d = RSS_ST_RUN;
               end
            end
         end
         RSS_ST_RUN: begin
            if (hrst_ok) begin
               st_d  = RSS_ST_HOLD;
               mem_d = 4'h0;
               sys_d = 4'h0;
            end
         end
         default: begin
            st_d = RSS_ST_POR;
         end
      endcase
      mem_rst_n_d = (st_d != RSS_ST_POR) && (st_d != RSS_ST_HOLD)
                    && (mem_d == 4'(`RSS_MEM_CYC));
      sys_rst_n_d = (st_d == RSS_ST_RUN);
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         st_q          <= RSS_ST_POR;
         por_q         <= '0;
         mem_q         <= 4'h0;
         sys_q         <= 4'h0;
         mem_rst_n_q   <= 1'b0;
         sys_rst_n_q   <= 1'b0;
         board_rst_n_q <= 1'b0;
      end else begin
         st_q          <= st_d;
         por_q         <= por_d;
         mem_q         <= mem_d;
         sys_q         <= sys_d;
         mem_rst_n_q   <= mem_rst_n_d;
         sys_rst_n_q   <= sys_rst_n_d;
         board_rst_n_q <= sys_rst_n_d;
      end
   end

   assign o_mem_rst_n             = mem_rst_n_q;
   assign o_system_rst_internal_n = sys_rst_n_q;
   assign o_board_rst_n           = board_rst_n_q;

   // checks
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   sys_board_same_a: assert property (o_system_rst_internal_n == o_board_rst_n)
      else $error("system and board reset differ");
   mem_before_sys_a: assert property (o_system_rst_internal_n |-> o_mem_rst_n)
      else $error("system reset released before memory reset");
   mem_count_hold_a: assert property ($rose(o_mem_rst_n) |-> mem_q == 4'(`RSS_MEM_CYC))
      else $error("memory reset released at wrong count");
   sys_count_rel_a: assert property ($rose(o_system_rst_internal_n) |-> sys_q == 4'(`RSS_SYS_CYC))
      else $error("system reset released at wrong count");
   por_done_a: assert property ($changed(st_q) && $past(st_q) == RSS_ST_POR
                                |-> por_q == PW'(POR_CYC - 1))
      else $error("power-up pulse ended early");
   por_hold_rst_a: assert property (st_q == RSS_ST_POR |-> !o_mem_rst_n && !o_board_rst_n)
      else $error("reset released during power-up pulse");
   qual_accept_a: assert property ($rose(hrst_ok)
                                   |-> $past(slow_tick) && $past(hrst_lvl_q))
      else $error("hard reset accepted before qualification");
   qual_clear_a: assert property (!hrst_lvl_q |=> qual_q == 3'h0)
      else $error("qualifier kept count after request ended");
   mem_on_tick_a: assert property ($rose(o_mem_rst_n) |-> $past(slow_tick))
      else $error("memory reset released off a slow tick");
   hold_restart_a: assert property (st_q == RSS_ST_HOLD |=> mem_q == 4'h0 && sys_q == 4'h0)
      else $error("stretchers not restarted during hard reset");
   hrst_to_rst_a: assert property (hrst_ok && st_q == RSS_ST_RUN |-> ##2 !o_board_rst_n)
      else $error("qualified hard reset did not reset");

   por_end_c: cover property (st_q == RSS_ST_POR ##1 st_q == RSS_ST_STR);
   run_c:     cover property ($rose(o_system_rst_internal_n));
   hrst_c:    cover property (st_q == RSS_ST_RUN ##1 st_q == RSS_ST_HOLD);
   short_c:   cover property ($fell(hrst_lvl_q) && qual_q < 3'(`RSS_QUAL_CYC));
   mem_rel_c: cover property ($rose(o_mem_rst_n));

endmodule : rss_reset_stretch_sequencer
`default_nettype wire

/* tb/rss_board_model.sv */
// Purpose: board side, slow oscillator and hard-reset button
// Assumes: oscillator already stable, slow clock scaled for sim
// Notes:   bench times request edges just after slow falling edges
`timescale 1ns/1ps
`default_nettype none
module rss_board_model #(
   parameter int HALF = 10
) (
   input  wire logic i_core_clk,
   output var  logic o_slow_clk,
   output var  logic o_hard_rst_n
);
   int cnt = 0;
   initial begin
      o_slow_clk   = 1'b0;
      o_hard_rst_n = 1'b1;
   end
   // free-running source, no start-up margin
   always @(posedge i_core_clk) begin
      #1;
      if (cnt == HALF - 1) begin
         cnt        = 0;
         o_slow_clk = ~o_slow_clk;
      end else begin
         cnt++;
      end
   end
   task automatic start_req();
      o_hard_rst_n = 1'b0;
   endtask : start_req
   task automatic end_req();
      o_hard_rst_n = 1'b1;
   endtask : end_req
endmodule : rss_board_model
`default_nettype wire

/* tb/rss_reset_stretch_sequencer_tb_top.sv */
// Purpose: self-checking bench of the reset stretch sequencer
// Assumes: short power-up count, fast slow clock
// Notes:   release times counted in slow rising edges
`timescale 1ns/1ps
`default_nettype none
module rss_reset_stretch_sequencer_tb_top;
   localparam int POR = 3;
   logic i_core_clk;
   logic i_nrst;
   logic slow;
   logic hard_n;
   logic mem_n;
   logic sys_n;
   logic brd_n;
   int   miscompares = 0;
   int   tests_run   = 0;
   rss_reset_stretch_sequencer #(.POR_CYC(POR)) rss_reset_stretch_sequencer_inst (
      .i_core_clk              (i_core_clk),
      .i_nrst                  (i_nrst),
      .i_slow_timing_clock     (slow),
      .i_hard_rst_n            (hard_n),
      .o_mem_rst_n             (mem_n),
      .o_system_rst_internal_n (sys_n),
      .o_board_rst_n           (brd_n)
   );
   rss_board_model rss_board_model_inst (
      .i_core_clk   (i_core_clk),
      .o_slow_clk   (slow),
      .o_hard_rst_n (hard_n)
   );
   initial begin
      i_core_clk = 1'b0;
      forever #2 i_core_clk = ~i_core_clk;
   end
   task automatic wrap_up();
      if (miscompares == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : wrap_up
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : check
   // slow ticks until memory (0) or system (1) reset releases
   task automatic ticks_to(input int which, output int n);
      logic prev;
      n    = 0;
      prev = slow;
      for (int k = 0; k < 3000; k++) begin
         @(posedge i_core_clk);
         if (slow && !prev) n++;
         prev = slow;
         #1;
         if ((which == 0) ? (mem_n === 1'b1) : (sys_n === 1'b1)) return;
      end
      miscompares++;
      wrap_up();
   endtask : ticks_to
   // waits for a number of rising (1) or falling (0) slow-clock edges
   task automatic wait_slow(input int edges, input logic rise);
      logic prev;
      int   seen;
      seen = 0;
      prev = slow;
      for (int k = 0; k < 3000; k++) begin
         @(posedge i_core_clk);
         if (slow !== prev && slow === rise) seen++;
         prev = slow;
         if (seen == edges) begin
            #1;
            return;
         end
      end
      miscompares++;
      wrap_up();
   endtask : wait_slow
   task automatic stretch_check(input int mem_exp);
      int a;
      int b;
      ticks_to(0, a);
      check(a, mem_exp);
      check({sys_n, brd_n}, 2'b00);
      ticks_to(1, b);
      check(a + b, mem_exp + 7);
      check({mem_n, sys_n, brd_n}, 3'b111);
   endtask : stretch_check
   task automatic sc_power_up();
      #1;
      check({mem_n, sys_n, brd_n}, 3'b000);
      i_nrst = 1'b1;
      stretch_check(POR + 7);
   endtask : sc_power_up
   task automatic sc_short_req();
      wait_slow(1, 1'b0);
      rss_board_model_inst.start_req();
      wait_slow(3, 1'b1);
      wait_slow(1, 1'b0);
      rss_board_model_inst.end_req();
      wait_slow(8, 1'b1);
      check({mem_n, sys_n, brd_n}, 3'b111);
   endtask : sc_short_req
   task automatic sc_long_req();
      wait_slow(1, 1'b0);
      rss_board_model_inst.start_req();
      wait_slow(3, 1'b1);
      wait_slow(1, 1'b0);
      check({mem_n, sys_n, brd_n}, 3'b111);
      wait_slow(3, 1'b1);
      check({mem_n, sys_n, brd_n}, 3'b000);
      wait_slow(1, 1'b0);
      rss_board_model_inst.end_req();
      stretch_check(7);
   endtask : sc_long_req
   initial begin
      i_nrst = 1'b0;
      repeat (12) @(posedge i_core_clk);
      sc_power_up();
      sc_short_req();
      sc_long_req();
      wrap_up();
   end
endmodule : rss_reset_stretch_sequencer_tb_top
`default_nettype wire
